// *** tccb_channel.sv ***
// One capture/compare channel: value register, active compare register and compare output.
`timescale 1ns/100ps
module tccb_channel
  import tccb_pkg::*;
(
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // Register write
  input  wire logic             i_write,
  input  wire logic [VAL_W-1:0] i_wdata,
  // Channel configuration
  input  wire logic             i_output_mode,
  input  wire logic             i_preload_enable,
  input  wire logic             i_capture_enable,
  // Timer events
  input  wire logic             i_update_event,
  input  wire logic             i_capture_event,
  input  wire logic [VAL_W-1:0] i_counter,
  // Results
  output logic [VAL_W-1:0]      o_value,
  output logic                  o_compare_out,
  output logic                  o_captured
);

  tccb_chan_s st;
  tccb_chan_s next_st;

  always_comb begin
    next_st          = st;
    next_st.captured = 1'b0;
    if (i_output_mode) begin
      if (i_write) begin
        next_st.value = i_wdata;
        if (!i_preload_enable) begin
          next_st.active = i_wdata;
        end
      end
      // The preload copy uses the value held before a same-cycle write.
      if (i_preload_enable && i_update_event) begin
        next_st.active = st.value;
      end
    end else if (i_capture_event && i_capture_enable) begin
      next_st.value    = i_counter;
      next_st.captured = 1'b1;
    end
    // Writes in input mode fall through untouched.
    next_st.compare_out = i_output_mode && (i_counter < next_st.active);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '{value: VALUE_RST, active: VALUE_RST, compare_out: 1'b0, captured: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_value       = st.value;
  assign o_compare_out = st.compare_out;
  assign o_captured    = st.captured;

endmodule

// *** tccb_chk.sv ***
// Port-level assertions for the timer burst access block.
`timescale 1ns/100ps
module tccb_chk
  import tccb_pkg::*;
(
  // Clock, reset and register port
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  // Timer side
  input wire logic [VAL_W-1:0]  i_timer_counter,
  input wire logic              i_update_event,
  input wire logic              i_ch2_capture_event,
  input wire logic              i_ch3_capture_event,
  input wire logic              i_ch4_capture_event,
  input wire logic              o_ch2_compare_out,
  input wire logic              o_ch3_compare_out,
  input wire logic              o_ch4_compare_out,
  input wire logic              o_dma_req,
  input wire logic              o_irq
);
  // ****************************************************************
  // Shadow of the burst setup
  // ****************************************************************
  // The shadow assumes the setup is not rewritten through the port itself.
  logic [FIELD_W-1:0] base_q;
  logic [FIELD_W-1:0] len_q;
  logic [FIELD_W-1:0] idx_q;
  logic               ude_q;
  logic               port_acc;
  logic [7:0]         target;
  assign port_acc = (i_wr | i_rd) && (i_addr[7:2] == OFF_BURST_PORT[7:2]);
  assign target = ({3'h0, base_q} + {3'h0, idx_q}) << 2;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      base_q <= '0;
      len_q <= '0;
      idx_q <= '0;
      ude_q <= 1'b0;
    end else begin
      if (i_wr && i_addr[7:2] == OFF_BURST_CTRL[7:2]) begin
        base_q <= i_wdata[4:0];
        len_q <= i_wdata[12:8];
      end
      if (i_wr && i_addr[7:2] == OFF_CHAN_CFG[7:2])
        ude_q <= i_wdata[UDE_BIT];
      if (i_update_event && ude_q)
        idx_q <= '0;
      else if (port_acc)
        idx_q <= (idx_q >= len_q) ? '0 : idx_q + 5'h1;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  value_upper_a: assert property ($past(i_rd && i_addr >= OFF_CH2_VALUE && i_addr < 8'h44)
    |-> o_rdata[31:16] == 16'h0) else $error("value register upper half not zero");
  ctrl_reserved_a: assert property ($past(i_rd && i_addr[7:2] == OFF_BURST_CTRL[7:2])
    |-> o_rdata[31:13] == 19'h0 && o_rdata[7:5] == 3'h0) else $error("burst control reserved set");
  port_redirect_a: assert property ($past(port_acc && i_rd && (target < 8'h38 || target == 8'h4c))
    |-> o_rdata == RDATA_ZERO) else $error("burst port read of empty target not zero");
  req_cause_a: assert property ($rose(o_dma_req) |-> $past(i_update_event) && $past(ude_q))
    else $error("burst request without enabled update");
  req_start_a: assert property ($past(i_update_event) && $past(ude_q) |-> o_dma_req)
    else $error("burst request missing after update");
  req_hold_a: assert property ($past(o_dma_req) && !$past(port_acc && idx_q >= len_q)
    |-> o_dma_req) else $error("burst request dropped early");
  req_drop_a: assert property ($past(port_acc && idx_q >= len_q && !i_update_event)
    |-> !o_dma_req) else $error("burst request held after last transfer");
  cmp_top_a: assert property ($past(i_timer_counter) == 16'hffff && i_timer_counter == 16'hffff
    |-> !(o_ch2_compare_out | o_ch3_compare_out | o_ch4_compare_out)) else $error("compare at top");
endmodule

bind tccb_top tccb_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_timer_counter(i_timer_counter), .i_update_event(i_update_event),
  .i_ch2_capture_event(i_ch2_capture_event), .i_ch3_capture_event(i_ch3_capture_event),
  .i_ch4_capture_event(i_ch4_capture_event), .o_ch2_compare_out(o_ch2_compare_out),
  .o_ch3_compare_out(o_ch3_compare_out), .o_ch4_compare_out(o_ch4_compare_out),
  .o_dma_req(o_dma_req), .o_irq(o_irq));

// *** tccb_dma_model.sv ***
// Behavioural DMA controller that streams a word buffer into the burst port.
`timescale 1ns/100ps
module tccb_dma_model
  import tccb_pkg::*;
(
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  // Handshake with the timer
  input  wire logic         i_dma_req,
  input  wire logic         i_stall,
  input  wire logic [5:0]   i_burst_n,
  // Bus master side
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wdata,
  output logic              o_wr
);
  logic [DATA_W-1:0] buffer[$];
  int                left;
  logic              armed;
  // One burst per request edge; an empty buffer ends the job, as nothing wraps around.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr <= 1'b0;
      o_addr <= OFF_BURST_PORT;
      o_wdata <= '0;
      left <= 0;
      armed <= 1'b1;
    end else if (left > 0 && !i_stall) begin
      o_wr <= 1'b1;
      o_wdata <= buffer.pop_front();
      left <= left - 1;
    end else begin
      o_wr <= 1'b0;
      o_wdata <= ~o_wdata;
      if (!i_dma_req)
        armed <= 1'b1;
      else if (armed && left == 0 && buffer.size() > 0) begin
        left <= int'(i_burst_n);
        armed <= 1'b0;
      end
    end
  end
endmodule

// *** tccb_pkg.sv ***
// Shared constants and state types for the capture/compare value and burst access block.
package tccb_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int VAL_W   = 16;
  localparam int CH_N    = 3;
  localparam int IDX_W   = 6;
  localparam int FIELD_W = 5;
  localparam int DIR_W   = 2;
  localparam int IRQ_W   = 4;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_CH2_VALUE   = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_CH3_VALUE   = 8'h3c;
  localparam logic [ADDR_W-1:0] OFF_CH4_VALUE   = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_BURST_CTRL  = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_BURST_PORT  = 8'h4c;
  localparam logic [ADDR_W-1:0] OFF_CHAN_CFG    = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS  = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK    = 8'h58;
  localparam logic [1:0]        WORD_LANE_BITS  = 2'h0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int VALUE_LSB  = 0;
  localparam int BASE_LSB   = 0;
  localparam int LEN_LSB    = 8;
  localparam int DIR_LSB    = 0;
  localparam int PE_LSB     = 8;
  localparam int CE_LSB     = 12;
  localparam int UDE_BIT    = 16;
  localparam int IRQ_CAP_LSB = 0;
  localparam int IRQ_DONE_BIT = 3;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [DIR_W-1:0]   DIR_OUTPUT    = 2'h0;
  localparam logic [VAL_W-1:0]   VALUE_RST     = 16'h0000;
  localparam logic [FIELD_W-1:0] FIELD_RST     = 5'h00;
  localparam logic [DATA_W-1:0]  RDATA_ZERO    = 32'h0000_0000;
  localparam logic [IRQ_W-1:0]   IRQ_RST       = 4'h0;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef struct packed {
    logic [VAL_W-1:0] value;
    logic [VAL_W-1:0] active;
    logic             compare_out;
    logic             captured;
  } tccb_chan_s;

  typedef struct packed {
    logic [FIELD_W-1:0]      burst_base_index;
    logic [FIELD_W-1:0]      burst_length;
    logic [FIELD_W-1:0]      dma_index;
    logic                    dma_req;
    logic [CH_N*DIR_W-1:0]   direction_select;
    logic [CH_N-1:0]         preload_enable;
    logic [CH_N-1:0]         capture_enable;
    logic                    update_dma_enable;
    logic [IRQ_W-1:0]        irq_status;
    logic [IRQ_W-1:0]        irq_mask;
    logic                    irq;
    logic [DATA_W-1:0]       rdata;
  } tccb_state_s;

endpackage

// *** tccb_top.sv ***
// Capture/compare values for channels 2 to 4 and the burst data access port of the timer.
`timescale 1ns/100ps
module tccb_top
  import tccb_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [DATA_W-1:0]      o_rdata,
  // Timer core
  input  wire logic [VAL_W-1:0]  i_timer_counter,
  input  wire logic              i_update_event,
  // Capture events from the input stage
  input  wire logic              i_ch2_capture_event,
  input  wire logic              i_ch3_capture_event,
  input  wire logic              i_ch4_capture_event,
  // Compare outputs
  output logic                   o_ch2_compare_out,
  output logic                   o_ch3_compare_out,
  output logic                   o_ch4_compare_out,
  // DMA request and interrupt
  output logic                   o_dma_req,
  output logic                   o_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  tccb_state_s st;
  tccb_state_s next_st;

  logic [CH_N-1:0]        ch_write;
  logic [CH_N-1:0]        ch_output_mode;
  logic [CH_N-1:0]        ch_capture_event;
  logic [CH_N-1:0]        ch_compare_out;
  logic [CH_N-1:0]        ch_captured;
  logic [CH_N*VAL_W-1:0]  ch_value;
  logic                   burst_access;
  logic [IDX_W-1:0]       eff_idx;
  logic [ADDR_W-1:0]      eff_addr;
  logic [IRQ_W-1:0]       irq_event;
  logic [IRQ_W-1:0]       irq_clear;
  logic                   burst_done;

  assign ch_capture_event = {i_ch4_capture_event, i_ch3_capture_event, i_ch2_capture_event};

  // ****************************************************************
  // Channels
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_ch
      assign ch_output_mode[g] = (st.direction_select[g*DIR_W +: DIR_W] == DIR_OUTPUT);
      tccb_channel u_ch (
        .i_sys_clk        (i_sys_clk),
        .i_rst            (i_rst),
        .i_write          (ch_write[g]),
        .i_wdata          (i_wdata[VALUE_LSB +: VAL_W]),
        .i_output_mode    (ch_output_mode[g]),
        .i_preload_enable (st.preload_enable[g]),
        .i_capture_enable (st.capture_enable[g]),
        .i_update_event   (i_update_event),
        .i_capture_event  (ch_capture_event[g]),
        .i_counter        (i_timer_counter),
        .o_value          (ch_value[g*VAL_W +: VAL_W]),
        .o_compare_out    (ch_compare_out[g]),
        .o_captured       (ch_captured[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Address redirection
  // ****************************************************************
  // Only registers of this block are reachable through the burst port; other
  // redirected targets read as zero and drop writes, since their data could not
  // arrive within the one-cycle read latency.
  always_comb begin
    // The byte lane bits are ignored here as for every other register.
    burst_access = (i_rd || i_wr) && (i_addr[ADDR_W-1:2] == OFF_BURST_PORT[ADDR_W-1:2]);
    if (i_addr[ADDR_W-1:2] == OFF_BURST_PORT[ADDR_W-1:2]) begin
      eff_idx = IDX_W'({1'b0, st.burst_base_index} + {1'b0, st.dma_index});
    end else begin
      eff_idx = i_addr[ADDR_W-1:2];
    end
    eff_addr = {eff_idx, WORD_LANE_BITS};
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st    = st;
    ch_write   = '0;
    irq_clear  = '0;
    burst_done = 1'b0;

    // Writes, routed through the redirected address.
    if (i_wr) begin
      case (eff_addr)
        OFF_CH2_VALUE: begin
          ch_write[0] = 1'b1;
        end
        OFF_CH3_VALUE: begin
          ch_write[1] = 1'b1;
        end
        OFF_CH4_VALUE: begin
          ch_write[2] = 1'b1;
        end
        OFF_BURST_CTRL: begin
          next_st.burst_length     = i_wdata[LEN_LSB +: FIELD_W];
          next_st.burst_base_index = i_wdata[BASE_LSB +: FIELD_W];
        end
        OFF_CHAN_CFG: begin
          for (int c = 0; c < CH_N; c++) begin
            // Direction may change only while capture is switched off.
            if (!st.capture_enable[c]) begin
              next_st.direction_select[c*DIR_W +: DIR_W] =
                i_wdata[DIR_LSB + c*DIR_W +: DIR_W];
            end
          end
          next_st.preload_enable    = i_wdata[PE_LSB +: CH_N];
          next_st.capture_enable    = i_wdata[CE_LSB +: CH_N];
          next_st.update_dma_enable = i_wdata[UDE_BIT];
        end
        OFF_IRQ_STATUS: begin
          irq_clear = i_wdata[IRQ_W-1:0];
        end
        OFF_IRQ_MASK: begin
          next_st.irq_mask = i_wdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Reads; data stands in the following cycle only.
    next_st.rdata = RDATA_ZERO;
    if (i_rd) begin
      case (eff_addr)
        OFF_CH2_VALUE: begin
          next_st.rdata[VALUE_LSB +: VAL_W] = ch_value[0*VAL_W +: VAL_W];
        end
        OFF_CH3_VALUE: begin
          next_st.rdata[VALUE_LSB +: VAL_W] = ch_value[1*VAL_W +: VAL_W];
        end
        OFF_CH4_VALUE: begin
          next_st.rdata[VALUE_LSB +: VAL_W] = ch_value[2*VAL_W +: VAL_W];
        end
        OFF_BURST_CTRL: begin
          next_st.rdata[LEN_LSB +: FIELD_W]  = st.burst_length;
          next_st.rdata[BASE_LSB +: FIELD_W] = st.burst_base_index;
        end
        OFF_CHAN_CFG: begin
          next_st.rdata[DIR_LSB +: CH_N*DIR_W] = st.direction_select;
          next_st.rdata[PE_LSB +: CH_N]        = st.preload_enable;
          next_st.rdata[CE_LSB +: CH_N]        = st.capture_enable;
          next_st.rdata[UDE_BIT]               = st.update_dma_enable;
        end
        OFF_IRQ_STATUS: begin
          next_st.rdata[IRQ_W-1:0] = st.irq_status;
        end
        OFF_IRQ_MASK: begin
          next_st.rdata[IRQ_W-1:0] = st.irq_mask;
        end
        default: begin
        end
      endcase
    end

    // Burst index walks from zero up to the length code.
    if (burst_access) begin
      if (st.dma_index >= st.burst_length) begin
        next_st.dma_index = FIELD_RST;
        next_st.dma_req   = 1'b0;
        burst_done        = 1'b1;
      end else begin
        next_st.dma_index = FIELD_W'(st.dma_index + 1'b1);
      end
    end

    // A new update request wins over the end of the previous burst.
    if (i_update_event && st.update_dma_enable) begin
      next_st.dma_index = FIELD_RST;
      next_st.dma_req   = 1'b1;
    end

    // Sticky status: a new event wins over a same-cycle clear.
    irq_event                     = '0;
    irq_event[IRQ_CAP_LSB +: CH_N] = ch_captured;
    irq_event[IRQ_DONE_BIT]       = burst_done;
    next_st.irq_status = (st.irq_status & ~irq_clear) | irq_event;
    next_st.irq        = |(next_st.irq_status & next_st.irq_mask);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '{
        burst_base_index:  FIELD_RST,
        burst_length:      FIELD_RST,
        dma_index:         FIELD_RST,
        dma_req:           1'b0,
        direction_select:  '0,
        preload_enable:    '0,
        capture_enable:    '0,
        update_dma_enable: 1'b0,
        irq_status:        IRQ_RST,
        irq_mask:          IRQ_RST,
        irq:               1'b0,
        rdata:             RDATA_ZERO
      };
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_rdata           = st.rdata;
  assign o_dma_req         = st.dma_req;
  assign o_irq             = st.irq;
  assign o_ch2_compare_out = ch_compare_out[0];
  assign o_ch3_compare_out = ch_compare_out[1];
  assign o_ch4_compare_out = ch_compare_out[2];

endmodule

// *** testbench.sv ***
// Self-checking bench: register traffic, DMA bursts, captures and compares.
`timescale 1ns/100ps
module testbench;
  import tccb_pkg::*;
  logic              i_sys_clk = 1'b0;
  logic              i_rst = 1'b1;
  logic [ADDR_W-1:0] b_addr = '0, m_addr, dut_addr;
  logic [DATA_W-1:0] b_wdata = '0, m_wdata, dut_wdata, o_rdata, eq[$];
  logic              b_wr = 1'b0, b_rd = 1'b0, m_wr, upd = 1'b0, stall = 1'b0, o_dma_req, o_irq;
  logic [VAL_W-1:0]  cnt = '0;
  logic [2:0]        cap = '0, cmp;
  int                seed = 3, miscompares = 0, n_tests = 0, val[3], act[3], outm[3] = '{1, 1, 1};
  always #50 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) stall <= 1'($random(seed));
  assign dut_addr = m_wr ? m_addr : b_addr;
  assign dut_wdata = m_wr ? m_wdata : b_wdata;
  tccb_top DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(dut_addr), .i_wdata(dut_wdata),
    .i_wr(b_wr | m_wr), .i_rd(b_rd), .o_rdata(o_rdata), .i_timer_counter(cnt),
    .i_update_event(upd), .i_ch2_capture_event(cap[0]), .i_ch3_capture_event(cap[1]),
    .i_ch4_capture_event(cap[2]), .o_ch2_compare_out(cmp[0]), .o_ch3_compare_out(cmp[1]),
    .o_ch4_compare_out(cmp[2]), .o_dma_req(o_dma_req), .o_irq(o_irq));
  tccb_dma_model dma (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_dma_req(o_dma_req),
    .i_stall(stall), .i_burst_n(6'd3), .o_addr(m_addr), .o_wdata(m_wdata), .o_wr(m_wr));
  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk) {b_addr, b_wdata, b_wr} <= {a, d, 1'b1};
    @(posedge i_sys_clk) b_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk) {b_addr, b_rd} <= {a, 1'b1};
    @(posedge i_sys_clk) b_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic pulse(input int n, input bit c);
    @(posedge i_sys_clk) {upd, cap} <= {n == 0, 1'b0, c, 1'b0};
    if (n != 0)
      cnt <= 16'($random(seed));
    @(posedge i_sys_clk) {upd, cap} <= '0;
    if (n == 1 && c)
      val[1] = cnt;
    repeat (3) @(posedge i_sys_clk);
  endtask
  task automatic set_vals(input bit pre);
    logic [31:0] w;
    for (int i = 0; i < 3; i++) begin
      w = $random(seed);
      wr32(OFF_CH2_VALUE + 8'(4 * i), w);
      val[i] = w[15:0];
      if (!pre)
        act[i] = val[i];
      rchk(OFF_CH2_VALUE + 8'(4 * i), 32'(val[i]));
    end
  endtask
  task automatic cmp_check();
    for (int k = 0; k < 3; k++) begin
      @(posedge i_sys_clk) cnt <= (k == 0) ? 16'hffff : 16'($random(seed));
      repeat (3) @(posedge i_sys_clk);
      #1;
      for (int i = 0; i < 3; i++)
        chk({31'h0, cmp[i]}, {31'h0, outm[i] != 0 && cnt < act[i]});
    end
  endtask
  task automatic port_reads(input int base, input int len, input int n);
    int t;
    for (int j = 0; j < n; j++) begin
      t = (base + j % (len + 1)) * 4;
      rchk(OFF_BURST_PORT, (t >= 'h38 && t <= 'h40) ? 32'(val[(t - 'h38) / 4]) : 32'h0);
    end
  endtask
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] w;
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rchk(OFF_BURST_CTRL, 32'h0);
    set_vals(1'b0);
    cmp_check();
    wr32(OFF_CHAN_CFG, 32'h700);
    set_vals(1'b1);
    cmp_check();
    pulse(0, 1'b0);
    #1 chk({31'h0, o_dma_req}, 32'h0);
    act = val;
    cmp_check();
    // ****************************************************************
    // Bursts driven by the DMA model
    // ****************************************************************
    wr32(OFF_CHAN_CFG, 32'h1_0000);
    wr32(OFF_BURST_CTRL, 32'h20e);
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      dma.buffer.push_back(w);
      eq.push_back(w);
    end
    for (int r = 0; r < 2; r++) begin
      pulse(0, 1'b0);
      for (int k = 0; dma.buffer.size() != 3 - 3 * r || m_wr; k++) begin
        if (k > 200) begin
          miscompares++;
          tally_and_finish();
        end
        @(posedge i_sys_clk) #1;
      end
      for (int i = 0; i < 3; i++) begin
        w = eq.pop_front();
        val[i] = w[15:0];
        rchk(OFF_CH2_VALUE + 8'(4 * i), 32'(val[i]));
      end
    end
    act = val;
    rchk(OFF_IRQ_STATUS, 32'h8);
    wr32(OFF_IRQ_STATUS, 32'h8);
    port_reads(14, 2, 6);
    wr32(OFF_BURST_CTRL, 32'h40b);
    port_reads(11, 4, 5);
    // ****************************************************************
    // Input mode on channel 3
    // ****************************************************************
    wr32(OFF_CHAN_CFG, 32'h4);
    wr32(OFF_CHAN_CFG, 32'h2004);
    outm[1] = 0;
    pulse(1, 1'b1);
    rchk(OFF_CH3_VALUE, 32'(val[1]));
    wr32(OFF_CH3_VALUE, 32'h1234);
    rchk(OFF_CH3_VALUE, 32'(val[1]));
    cmp_check();
    rchk(OFF_IRQ_STATUS, 32'ha);
    wr32(OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge i_sys_clk);
    #1 chk({31'h0, o_irq}, 32'h1);
    wr32(OFF_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge i_sys_clk);
    #1 chk({31'h0, o_irq}, 32'h0);
    wr32(OFF_CHAN_CFG, 32'h4);
    pulse(2, 1'b1);
    rchk(OFF_CH3_VALUE, 32'(val[1]));
    wr32(8'h60, 32'hffff_ffff);
    rchk(8'h60, 32'h0);
    tally_and_finish();
  end
endmodule
